// file: hw/i2c_target.sv
/*
  Serial bus target: condition detect, byte engine and register file.
  Assumes scl is the bus clock from the host and sda the bus data level.
*/
`timescale 1ns/100ps
`include "tsense_regs.svh"
module bus_cond (
  input wire logic scl, // Bus clock
  input wire logic sda, // Bus data level
  input wire logic rst, // Asynchronous reset, high
  input wire logic drive_d, // Wanted pull-down
  output logic start_tgl, // Flips on each start
  output logic drive_q // Pull-down, launched in clock low
);
  // Start mark: data falls while clock high
  always_ff @(negedge sda or posedge rst)
  begin
    if (rst)
      start_tgl <= 1'b0;
    else if (scl)
      start_tgl <= ~start_tgl;
  end

  always_ff @(negedge scl or posedge rst)
  begin
    if (rst)
      drive_q <= 1'b0;
    else
      drive_q <= drive_d;
  end
endmodule

module i2c_target #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input wire logic scl, // Bus clock
  input wire logic sda, // Bus data level
  input wire logic rst, // Asynchronous reset, high
  reg_link_if.link lk // Register carrier
);
  import tsense_pkg::*;

  link_s q, d;
  logic start_tgl;
  logic [7:0] wb;
  logic [7:0] rb;

  function automatic logic [7:0] rd_byte(input link_s s,
    input logic [1:0] idx);
    rd_byte = 8'h00;
    if (idx == 2'h0)
    begin
      if (s.ptr == `PTR_TEMP)
        rd_byte = s.temp[10:3];
      else if (s.ptr == `PTR_CONF)
        rd_byte = s.cfg;
      else if (s.ptr == `PTR_HYST)
        rd_byte = s.hyst[8:1];
      else
        rd_byte = s.over[8:1];
    end
    else if (idx == 2'h1)
    begin
      if (s.ptr == `PTR_TEMP)
        rd_byte = {s.temp[2:0], 5'h00};
      else if (s.ptr == `PTR_HYST)
        rd_byte = {s.hyst[0], 7'h00};
      else if (s.ptr == `PTR_OVER)
        rd_byte = {s.over[0], 7'h00};
    end
  endfunction

  bus_cond u_cond (
    .scl(scl),
    .sda(sda),
    .rst(rst),
    .drive_d(q.drive),
    .start_tgl(start_tgl),
    .drive_q(lk.sda_drive)
  );

  always_comb
  begin
    d = q;
    wb = {q.sh[6:0], sda};
    rb = rd_byte(q, q.idx);
    d.ts1 = lk.temp_tgl;
    d.ts2 = q.ts1;
    if (q.ts2 != q.tseen)
    begin
      d.tseen = q.ts2;
      d.temp = lk.temp;
    end
    // Start mark is settled well before the first rising clock
    if (start_tgl != q.sseen)
    begin
      d.sseen = start_tgl;
      d.st = ST_ADDR;
      d.sh = {7'h00, sda};
      d.bitc = 3'h1;
      d.idx = 2'h0;
      d.drive = 1'b0;
    end
    else
      case (q.st)
        ST_ADDR:
        begin
          d.sh = wb;
          d.bitc = q.bitc + 3'h1;
          if (q.bitc == 3'h7)
          begin
            d.rw = sda;
            d.drive = (q.sh[6:0] == ADDR);
            d.st = (q.sh[6:0] == ADDR) ? ST_ACKA : ST_IDLE;
          end
        end
        ST_ACKA:
        begin
          d.bitc = 3'h0;
          if (q.rw)
          begin
            d.sh = rb;
            d.drive = ~rb[7];
            d.rd_tgl = ~q.rd_tgl;
            d.idx = 2'h1;
            d.st = ST_RBYTE;
          end
          else
          begin
            d.drive = 1'b0;
            d.st = ST_WBYTE;
          end
        end
        ST_RBYTE:
        begin
          if (q.bitc == 3'h7)
          begin
            d.drive = 1'b0;
            d.st = ST_ACKR;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.drive = ~q.sh[6];
            d.bitc = q.bitc + 3'h1;
          end
        end
        ST_ACKR:
        begin
          d.bitc = 3'h0;
          if (!sda)
          begin
            d.sh = rb;
            d.drive = ~rb[7];
            d.idx = (q.idx == 2'h3) ? q.idx : q.idx + 2'h1;
            d.st = ST_RBYTE;
          end
          else
            d.st = ST_IDLE;
        end
        ST_WBYTE:
        begin
          d.sh = wb;
          d.bitc = q.bitc + 3'h1;
          if (q.bitc == 3'h7)
          begin
            d.drive = 1'b1;
            d.st = ST_ACKW;
            if (q.idx == 2'h0)
              d.ptr = wb[1:0];
            else if (q.idx == 2'h1 && q.ptr == `PTR_CONF)
            begin
              d.cfg = wb;
              d.wr_tgl = ~q.wr_tgl;
            end
            else if (q.idx == 2'h1)
              d.wmsb = wb;
            else if (q.idx == 2'h2 && q.ptr == `PTR_HYST)
            begin
              d.hyst = {q.wmsb, wb[7]};
              d.wr_tgl = ~q.wr_tgl;
            end
            else if (q.idx == 2'h2 && q.ptr == `PTR_OVER)
            begin
              d.over = {q.wmsb, wb[7]};
              d.wr_tgl = ~q.wr_tgl;
            end
          end
        end
        ST_ACKW:
        begin
          d.drive = 1'b0;
          d.bitc = 3'h0;
          d.st = ST_WBYTE;
          if (q.idx != 2'h3)
            d.idx = q.idx + 2'h1;
        end
        ST_IDLE:
          d.drive = 1'b0;
        default:
          d.st = ST_IDLE;
      endcase
  end

  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cfg <= `CONF_RST;
      q.over <= `OVER_RST;
      q.hyst <= `HYST_RST;
      q.ptr <= `PTR_TEMP;
    end
    else
      q <= d;
  end

  assign lk.cfg = q.cfg;
  assign lk.over = q.over;
  assign lk.hyst = q.hyst;
  assign lk.wr_tgl = q.wr_tgl;
  assign lk.rd_tgl = q.rd_tgl;

  ////////////////////////////////////////////////////////////////////////
  a_ack_drive: assert property (@(posedge scl) disable iff (rst)
    q.st == ST_ACKA || q.st == ST_ACKW |-> q.drive)
    else $error("acknowledge not driven low");
  a_nack_free: assert property (@(posedge scl) disable iff (rst)
    q.st == ST_ACKR |-> !q.drive)
    else $error("data line held in host acknowledge slot");
endmodule

// file: hw/tsense_regs.svh
/*
  Register pointers, field positions, reset values and timing figures of
  the thermal watchdog.
  Assumes inclusion by bare name from the design files.
*/
`ifndef TSENSE_REGS_SVH
`define TSENSE_REGS_SVH

// Register pointer codes
`define PTR_TEMP 2'h0
`define PTR_CONF 2'h1
`define PTR_HYST 2'h2
`define PTR_OVER 2'h3

// Configuration field positions
`define CONF_SHDN 0
`define CONF_MODE 1
`define CONF_POL 2
`define CONF_FQ_LO 3
`define CONF_FQ_HI 4

// Power-up values (80 and 75 degrees at half-degree steps)
`define CONF_RST 8'h00
`define OVER_RST 9'h0A0
`define HYST_RST 9'h096

// Timing
`define CLK_HZ 25000000
`define CONV_MS 100
`define TOUT_MS 75

`endif

// file: hw/tsense_pkg.sv
/*
  Types shared by the watchdog core, the fault judge and the serial target.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tsense_pkg;
  typedef logic [10:0] temp_t;
  typedef logic [8:0] limit_t;
  typedef logic [7:0] conf_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACKA = 7'h04,
    ST_WBYTE = 7'h08,
    ST_ACKW = 7'h10,
    ST_RBYTE = 7'h20,
    ST_ACKR = 7'h40
  } link_st_e;

  typedef struct packed {
    link_st_e st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic rw;
    logic [1:0] ptr;
    logic [1:0] idx;
    logic [7:0] wmsb;
    conf_t cfg;
    limit_t over;
    limit_t hyst;
    temp_t temp;
    logic ts1;
    logic ts2;
    logic tseen;
    logic sseen;
    logic wr_tgl;
    logic rd_tgl;
    logic drive;
  } link_s;

  typedef struct packed {
    logic act;
    logic hunt_low;
    logic [2:0] cnt;
  } judge_s;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic sda1;
    logic sda2;
    logic sda3;
    logic wr1;
    logic wr2;
    logic wrseen;
    logic rd1;
    logic rd2;
    logic rdseen;
    logic cfg_written;
    conf_t cfg;
    limit_t over;
    limit_t hyst;
    temp_t temp;
    logic temp_tgl;
    logic shdn_prev;
    logic [31:0] conv_cnt;
    logic conv_req;
    logic [31:0] tout_cnt;
    logic abort;
    logic alarm_oe;
  } core_s;
endpackage

// file: hw/tsense_if.sv
/*
  Carriers between the watchdog core and its two sub-blocks.
  Assumes the core owns the reference clock and the target the bus clock.
*/
`timescale 1ns/100ps
interface reg_link_if;
  import tsense_pkg::*;
  conf_t cfg;
  limit_t over;
  limit_t hyst;
  logic wr_tgl;
  logic rd_tgl;
  logic sda_drive;
  temp_t temp;
  logic temp_tgl;
  modport link (output cfg, over, hyst, wr_tgl, rd_tgl, sda_drive,
    input temp, temp_tgl);
  modport core (input cfg, over, hyst, wr_tgl, rd_tgl, sda_drive,
    output temp, temp_tgl);
endinterface

interface judge_if;
  import tsense_pkg::*;
  logic conv;
  limit_t temp9;
  limit_t over;
  limit_t hyst;
  logic mode;
  logic [1:0] fq;
  logic shdn_rise;
  logic read_evt;
  logic active;
  modport judge (input conv, temp9, over, hyst, mode, fq, shdn_rise,
    read_evt, output active);
  modport core (output conv, temp9, over, hyst, mode, fq, shdn_rise,
    read_evt, input active);
endinterface

// file: hw/trip_judge.sv
/*
  Limit comparison, fault queue and alarm state of the watchdog.
  Assumes all inputs on the reference clock; conv is a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "tsense_regs.svh"
module trip_judge (
  input wire logic clk, // Reference clock
  input wire logic rst, // Asynchronous reset, high
  judge_if.judge jd // Judge carrier
);
  import tsense_pkg::*;

  judge_s q, d;
  logic cond;
  logic [2:0] len;

  function automatic logic [2:0] fq_len(input logic [1:0] code);
    case (code)
      2'h0: fq_len = 3'h1;
      2'h1: fq_len = 3'h2;
      2'h2: fq_len = 3'h4;
      default: fq_len = 3'h6;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    len = fq_len(jd.fq);
    if ((jd.mode && q.hunt_low) || (!jd.mode && q.act))
      cond = $signed(jd.temp9) < $signed(jd.hyst);
    else
      cond = $signed(jd.temp9) > $signed(jd.over);
    if (jd.mode && (jd.read_evt || jd.shdn_rise))
      d.act = 1'b0;
    if (jd.conv)
    begin
      if (!cond)
        d.cnt = 3'h0;
      else if (q.cnt + 3'h1 >= len)
      begin
        d.cnt = 3'h0;
        if (jd.mode)
        begin
          d.act = 1'b1;
          d.hunt_low = ~q.hunt_low;
        end
        else
          d.act = ~q.act;
      end
      else
        d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign jd.active = q.act;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cmp_hold: assert property (!jd.mode && !jd.conv |=> $stable(q.act))
    else $error("comparator alarm moved without a conversion");
  a_int_clear: assert property (jd.mode && jd.read_evt && !jd.conv
    |=> !q.act)
    else $error("read did not clear interrupt alarm");
  a_shdn_int: assert property (jd.mode && jd.shdn_rise && !jd.conv
    |=> !q.act)
    else $error("shutdown did not clear interrupt alarm");
  a_queue_bound: assert property (q.cnt < 3'h6)
    else $error("fault count beyond longest queue");
  a_conv_only: assert property ($rose(q.act) |-> $past(jd.conv))
    else $error("alarm raised outside a conversion end");
  c_int_trip: cover property (jd.mode && $rose(q.act));
endmodule

// file: hw/thermal_alarm_watchdog.sv
/*
  Thermal watchdog top: conversion pacing, result register, limit
  snapshot, bus fault time-out and open-drain alarm and data pins.
  Assumes a converter on REF_CLK answering CONV_START with CONV_DONE
  and TEMP_DATA, and a bus host clocking SCL_IN.
*/
// What this block does
// - Polarity bit sets alarm active level
// - Polarity resets to zero, alarm active low
// - Mode bit picks interrupt or comparator
// - Comparator alarm follows limits, ignores reads
// - Interrupt alarm latches until any read
// - Faults judged per conversion, consecutive count
// - Queue code gives 1, 2, 4, 6
// - Shutdown bit stops or resumes conversions
// - Bus stays usable during shutdown
// - Shutdown clears alarm only in interrupt
// - Power-up defaults: 80, 75, pointer temp
// - Nine clocks per byte incl. acknowledge
// - Data changes only while clock low
// - Device pulls acknowledge low, host releases
// - Both release line for final not-acknowledge
// - Single-byte read never locks the bus
// - Release bus after long data low
// - Compare only nine top result bits
// - Result eleven bits, left-justified, zeros below
`timescale 1ns/100ps
`include "tsense_regs.svh"
module thermal_alarm_watchdog #(
  parameter logic [6:0] ADDR = 7'h48,
  parameter int CONV_CYCLES = `CONV_MS * (`CLK_HZ / 1000),
  parameter int TOUT_CYCLES = `TOUT_MS * (`CLK_HZ / 1000)
) (
  input wire logic REF_CLK, // Core clock
  input wire logic RST, // Asynchronous reset, high
  input wire logic SCL_IN, // Bus clock from host
  input wire logic SDA_IN, // Bus data level
  output logic SDA_OUT, // Bus data drive value
  output logic SDA_OE, // Bus data pull-down enable
  output logic ALARM_OUT, // Alarm drive value
  output logic ALARM_OE, // Alarm pull-down enable
  output logic CONV_START, // Conversion request pulse
  input wire logic CONV_DONE, // Conversion finished pulse
  input wire tsense_pkg::temp_t TEMP_DATA // Conversion result
);
  import tsense_pkg::*;

  core_s q, d;
  logic start_seen;
  logic wr_evt;
  logic rd_evt;
  logic shdn;
  logic accept;

  reg_link_if lk ();
  judge_if jd ();

  ////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  i2c_target #(
    .ADDR(ADDR)
  ) u_target (
    .scl(SCL_IN),
    .sda(SDA_IN),
    .rst(RST),
    .lk(lk.link)
  );

  trip_judge u_judge (
    .clk(REF_CLK),
    .rst(RST),
    .jd(jd.judge)
  );

  ////////////////////////////////////////////////////////////////////////
  // Events seen on the core clock

  assign shdn = q.cfg[`CONF_SHDN];
  assign start_seen = q.scl2 && q.sda3 && !q.sda2;
  assign wr_evt = q.wr2 != q.wrseen;
  assign rd_evt = q.rd2 != q.rdseen;
  assign accept = CONV_DONE && !shdn;

  assign jd.conv = accept;
  assign jd.temp9 = TEMP_DATA[10:2];
  assign jd.over = q.over;
  assign jd.hyst = q.hyst;
  assign jd.mode = q.cfg[`CONF_MODE];
  assign jd.fq = q.cfg[`CONF_FQ_HI:`CONF_FQ_LO];
  assign jd.shdn_rise = shdn && !q.shdn_prev;
  assign jd.read_evt = rd_evt;

  assign lk.temp = q.temp;
  assign lk.temp_tgl = q.temp_tgl;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    d.scl1 = SCL_IN;
    d.scl2 = q.scl1;
    d.sda1 = SDA_IN;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.wr1 = lk.wr_tgl;
    d.wr2 = q.wr1;
    d.rd1 = lk.rd_tgl;
    d.rd2 = q.rd1;
    d.rdseen = q.rd2;
    d.shdn_prev = shdn;
    // Bus values change on the same bus clock edge as their toggle
    if (wr_evt)
    begin
      d.wrseen = q.wr2;
      d.cfg = lk.cfg;
      d.over = lk.over;
      d.hyst = lk.hyst;
      d.cfg_written = 1'b1;
    end
    // Conversion pacing
    d.conv_req = 1'b0;
    if (shdn)
      d.conv_cnt = 32'h0;
    else if (q.conv_cnt >= 32'(CONV_CYCLES - 1))
    begin
      d.conv_cnt = 32'h0;
      d.conv_req = 1'b1;
    end
    else
      d.conv_cnt = q.conv_cnt + 32'h1;
    if (accept)
    begin
      d.temp = TEMP_DATA;
      d.temp_tgl = ~q.temp_tgl;
    end
    // Stuck data line watch
    if (q.sda2)
      d.tout_cnt = 32'h0;
    else if (q.tout_cnt >= 32'(TOUT_CYCLES - 1))
      d.abort = 1'b1;
    else
      d.tout_cnt = q.tout_cnt + 32'h1;
    if (start_seen)
      d.abort = 1'b0;
    d.alarm_oe = jd.active ^ q.cfg[`CONF_POL];
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
      q.scl1 <= 1'b1;
      q.scl2 <= 1'b1;
      q.sda1 <= 1'b1;
      q.sda2 <= 1'b1;
      q.sda3 <= 1'b1;
      q.cfg <= `CONF_RST;
      q.over <= `OVER_RST;
      q.hyst <= `HYST_RST;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins

  assign SDA_OUT = 1'b0;
  assign SDA_OE = lk.sda_drive && !q.abort;
  assign ALARM_OUT = 1'b0;
  assign ALARM_OE = q.alarm_oe;
  assign CONV_START = q.conv_req;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_pol_high: assert property (jd.active && q.cfg[`CONF_POL]
    && $stable(q.cfg) |=> !ALARM_OE)
    else $error("active-high alarm is pulling low");
  a_pol_low: assert property (jd.active && !q.cfg[`CONF_POL]
    && $stable(q.cfg) |=> ALARM_OE)
    else $error("active-low alarm not pulling low");
  a_boot_values: assert property (!q.cfg_written |->
    q.cfg == `CONF_RST && q.over == `OVER_RST
    && q.hyst == `HYST_RST)
    else $error("power-up values lost without a write");
  a_shdn_halt: assert property (shdn && $past(shdn) |-> !CONV_START)
    else $error("conversion requested in shutdown");
  a_conv_gap: assert property (CONV_START |=> !CONV_START [*2])
    else $error("conversion requests too close");
  a_temp_load: assert property (accept |=>
    q.temp == $past(TEMP_DATA) && q.temp_tgl != $past(q.temp_tgl))
    else $error("result register not loaded");
  a_shdn_keep: assert property (shdn && CONV_DONE |=>
    $stable(q.temp))
    else $error("result changed during shutdown");
  a_abort_free: assert property (q.abort |-> !SDA_OE)
    else $error("data line driven after time-out");
  a_tout_bound: assert property (q.tout_cnt < 32'(TOUT_CYCLES))
    else $error("time-out counter overran");
  a_cmp_read: assert property (!jd.mode && rd_evt && !accept
    |=> $stable(jd.active))
    else $error("read changed comparator alarm");

  c_conv: cover property (accept ##[1:1000] CONV_START);
  c_abort: cover property ($rose(q.abort));
  c_write: cover property (wr_evt && q.cfg_written);
endmodule

// file: test/i2c_host_model.sv
/*
  Serial bus host model: start, stop, single bit, byte write and read.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/100ps
module i2c_host_model (
  output logic scl, // Bus clock, high at rest
  output logic sda_oe, // Pulls data low
  input wire logic sda // Resolved data level
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic bitx(input logic b, output logic r);
    #1.5 sda_oe = ~b;
    #1.5 scl = 1'b1;
    r = sda;
    #3 scl = 1'b0;
  endtask

  // Start held long enough for the core clock to see it
  task automatic start;
    #1.5 sda_oe = 1'b0;
    #1.5 scl = 1'b1;
    #100 sda_oe = 1'b1;
    #100 scl = 1'b0;
  endtask

  task automatic stop;
    #1.5 sda_oe = 1'b1;
    #1.5 scl = 1'b1;
    #1.5 sda_oe = 1'b0;
    #1.5;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~more, r);
  endtask
endmodule

// file: test/thermal_alarm_watchdog_tb_top.sv
/*
  Bench of the thermal watchdog: bus host, converter stand-in, checks.
  Assumes the design with short conversion and time-out parameters.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module thermal_alarm_watchdog_tb_top;
  import tsense_pkg::*;
  localparam logic [6:0] ADR = 7'h48;
  localparam int CONV = 50;
  localparam int TOUT = 40;
  localparam int LIMIT = 30000;
  logic ref_clk, rst, scl, host_oe, sda, sda_out, sda_oe;
  logic alarm_out, alarm_oe, conv_start;
  logic conv_done = 1'b0;
  temp_t temp_data = 11'h000;
  temp_t cur = 11'h000;
  logic [2:0] dly = 3'h0;
  logic [31:0] seed = 32'h567A;
  limit_t ov9 = 9'h0B5;
  limit_t hy9 = 9'h096;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  assign sda = ~(host_oe | (sda_oe & ~sda_out));

  thermal_alarm_watchdog #(.ADDR(ADR), .CONV_CYCLES(CONV),
    .TOUT_CYCLES(TOUT)) dut (.REF_CLK(ref_clk), .RST(rst), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ALARM_OUT(alarm_out), .ALARM_OE(alarm_oe), .CONV_START(conv_start),
    .CONV_DONE(conv_done), .TEMP_DATA(temp_data));
  i2c_host_model host (.scl(scl), .sda_oe(host_oe), .sda(sda));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Converter stand-in and run limit
  always @(posedge ref_clk)
  begin
    dly <= {dly[1:0], conv_start};
    conv_done <= dly[2];
    temp_data <= cur;
    cyc++;
    if (cyc == LIMIT)
    begin
      errors++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int fq_n(input int k);
    case (k)
      0: return 1;
      1: return 2;
      2: return 4;
      default: return 6;
    endcase
  endfunction

  task automatic set_temp(input logic h);
    seed = xs(seed);
    if (h)
      cur <= {ov9 + 9'h001 + {5'h00, seed[3:0]}, seed[5:4]};
    else
      cur <= {hy9 - 9'h001 - {5'h00, seed[3:0]}, seed[5:4]};
  endtask

  task automatic conv(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge ref_clk);
      while (conv_done !== 1'b1) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic chk_al(input logic act, input logic pol);
    `CHK("alarm", act ^ pol, alarm_oe)
    `CHK("alarm level", 1'b0, alarm_out)
  endtask

  task automatic wr(input logic [1:0] p, input int n, input logic [15:0] v);
    logic a;
    host.start;
    host.wbyte({ADR, 1'b0}, a);
    `CHK("ack addr", 1'b0, a)
    host.wbyte({6'h00, p}, a);
    if (n > 0) host.wbyte(v[15:8], a);
    if (n > 1) host.wbyte(v[7:0], a);
    `CHK("ack data", 1'b0, a)
    host.stop;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [1:0] p, input int n, output logic [15:0] v);
    logic a;
    v = 16'h0000;
    host.start;
    host.wbyte({ADR, 1'b0}, a);
    host.wbyte({6'h00, p}, a);
    host.start;
    host.wbyte({ADR, 1'b1}, a);
    `CHK("ack read", 1'b0, a)
    host.rbyte(n > 1, v[15:8]);
    if (n > 1) host.rbyte(1'b0, v[7:0]);
    host.stop;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] v;
    logic [7:0] cf;
    logic a;
    int c;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("alarm rst", 1'b0, alarm_oe)
    rd(1, 1, v);
    `CHK("conf rst", 8'h00, v[15:8])
    rd(2, 2, v);
    `CHK("hyst rst", 16'h4B00, v)
    rd(3, 2, v);
    `CHK("over rst", 16'h5000, v)
    wr(3, 2, {ov9, 7'h00});
    rd(3, 2, v);
    `CHK("over", {ov9, 7'h00}, v)
    conv(1);
    cur <= {ov9, 2'b11};
    conv(2);
    chk_al(1'b0, 1'b0);
    rd(0, 1, v);
    `CHK("temp msb", cur[10:3], v[15:8])
    rd(0, 2, v);
    `CHK("temp", {cur, 5'h00}, v)
    host.start;
    host.wbyte({7'h49, 1'b0}, a);
    host.stop;
    `CHK("foreign addr", 1'b1, a)
    for (int k = 0; k < 4; k++)
    begin
      cf = {3'h0, k[1:0], k[0], 2'b00};
      set_temp(1'b0);
      conv(7);
      wr(1, 1, {cf, 8'h00});
      conv(1);
      set_temp(1'b1);
      conv(fq_n(k) - 1);
      chk_al(1'b0, k[0]);
      conv(1);
      chk_al(1'b1, k[0]);
      rd(1, 1, v);
      `CHK("conf", cf, v[15:8])
      chk_al(1'b1, k[0]);
      set_temp(1'b0);
      conv(fq_n(k) - 1);
      chk_al(1'b1, k[0]);
      conv(1);
      chk_al(1'b0, k[0]);
    end
    // Comparator alarm through shutdown
    wr(1, 1, 16'h0000);
    conv(1);
    set_temp(1'b1);
    conv(1);
    chk_al(1'b1, 1'b0);
    wr(1, 1, 16'h0100);
    chk_al(1'b1, 1'b0);
    c = 0;
    repeat (150) @(posedge ref_clk) c += int'(conv_start === 1'b1);
    `CHK("starts", 0, c)
    rd(1, 1, v);
    `CHK("conf shdn", 8'h01, v[15:8])
    wr(1, 1, 16'h0000);
    set_temp(1'b0);
    conv(1);
    chk_al(1'b0, 1'b0);
    // Interrupt mode
    wr(1, 1, 16'h0200);
    conv(1);
    set_temp(1'b1);
    conv(1);
    chk_al(1'b1, 1'b0);
    conv(1);
    chk_al(1'b1, 1'b0);
    rd(2, 2, v);
    chk_al(1'b0, 1'b0);
    conv(1);
    chk_al(1'b0, 1'b0);
    set_temp(1'b0);
    conv(1);
    chk_al(1'b1, 1'b0);
    rd(1, 1, v);
    chk_al(1'b0, 1'b0);
    set_temp(1'b1);
    conv(1);
    chk_al(1'b1, 1'b0);
    wr(1, 1, 16'h0300);
    chk_al(1'b0, 1'b0);
    wr(1, 1, 16'h0000);
    // Data line held low in the acknowledge bit
    v = {8'h00, ADR, 1'b0};
    host.start;
    for (int i = 7; i >= 0; i--) host.bitx(v[i], a);
    #3;
    `CHK("ack drive", 1'b1, sda_oe)
    repeat (2 * TOUT) @(posedge ref_clk);
    `CHK("bus release", 1'b0, sda_oe)
    host.bitx(1'b1, a);
    host.stop;
    rd(1, 1, v);
    `CHK("conf after", 8'h00, v[15:8])
    final_report;
  end
endmodule
